// File: hdl/cdac_top.sv
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// RULE_01: range 00 0.5mA, 01 1mA, 1x 2mA
// RULE_02: control resets to 01110010
// RULE_03: enable bit hands pin to converter
// RULE_04: enabled converter requests bandgap bias
// RULE_05: software sets crossbar skip bit for pin
// RULE_06: source 111 updates on high-byte write
// RULE_07: low write held until next high write
// RULE_08: software writes low byte then high
// RULE_09: 8-bit use: fixed low, write high
// RULE_10: codes 000-011 update on timer overflows
// RULE_11: codes 100-110 update on strobe edge
// RULE_12: 100 rise, 101 fall, 110 both
// RULE_13: data left-justified across high/low bytes
// RULE_14: strobe synchronised, edges give one pulse
// RULE_15: timer overflow pulse loads latch directly
module cdac_top (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave port
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // update event sources
  input  wire logic [3:0]            timer_overflow,
  input  wire logic                  external_conversion_strobe,
  // ordinary pin controls from the port logic
  input  wire logic                  gpio_out,
  input  wire logic                  gpio_oe,
  input  wire logic                  gpio_pullup_en,
  // pad controls
  output logic                       pin_out,
  output logic                       pin_oe,
  output logic                       pin_pullup_en,
  output logic                       pin_analog_connect,
  // analog-facing bundle
  output cdac_pkg::cdac_analog_t     analog
);

  // address phase capture
  // one transfer in flight at most, since the slave never stalls
  cdac_pkg::cdac_aphase_t aphase;
  cdac_pkg::cdac_aphase_t next_aphase;
  // software-visible registers
  // data bytes keep only what software wrote; the latch is separate
  logic [7:0]             dac_control;
  logic [7:0]             next_dac_control;
  logic [7:0]             dac_data_high;
  logic [7:0]             next_dac_data_high;
  logic [7:0]             dac_data_low;
  logic [7:0]             next_dac_data_low;
  // converter input latch, the word the current source sees
  // held apart from the data bytes so writes wait for an event
  logic [9:0]             input_latch;
  logic [9:0]             next_input_latch;
  // strobe synchroniser and edge history
  // only the second and third flops feed the edge logic; the first may be metastable
  logic                   strobe_meta;
  logic                   strobe_sync;
  logic                   strobe_prev;
  logic                   next_strobe_meta;
  logic                   next_strobe_sync;
  logic                   next_strobe_prev;
  // decoded write strobes, data phase
  // each one is high for the single data-phase cycle of a write
  logic                   wr_control;
  logic                   wr_high;
  logic                   wr_low;
  // update event for this cycle
  // one load per cycle, however many sources would fire
  logic                   load_latch;
  logic [2:0]             src;
  logic                   rise_pulse;
  logic                   fall_pulse;
  logic [7:0]             high_now;
  logic [7:0]             low_now;

  // left-justified packing of the two bytes into one word
  // high byte gives bits 9:2, low byte bits 7:6 give bits 1:0
  function automatic logic [9:0] pack_word(input logic [7:0] hi, input logic [7:0] lo);
    pack_word = {hi, lo[7:6]};
  endfunction

  // one register per aligned word; other addresses read zero
  // byte lanes are ignored, so a narrow access still hits the word
  function automatic logic reg_index_hit(input logic [11:0] a, input logic [11:0] target);
    reg_index_hit = (a == target);
  endfunction

  // address phase: latch when slave selected and bus ready
  // idle and busy transfers leave valid low, so no data phase follows
  always_comb begin
    // hold while another slave stretches its data phase
    next_aphase = aphase;
    // a new address phase is only taken when the bus moves on
    if (hready) begin
      next_aphase.valid = hsel && (htrans == cdac_pkg::HTRANS_NONSEQ || htrans == cdac_pkg::HTRANS_SEQ);
      next_aphase.write = hwrite;
      next_aphase.addr  = {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    // cleared so reset leaves no pending transfer
    if (!hresetn) begin
      aphase <= '0;
    end else begin
      aphase <= next_aphase;
    end
  end

  // data-phase write decode; zero wait states so data is here now
  // writes to the readback word or unmapped words match nothing
  always_comb begin
    wr_control = aphase.valid && aphase.write && reg_index_hit(aphase.addr, cdac_pkg::ADDR_CONTROL);
    wr_high    = aphase.valid && aphase.write && reg_index_hit(aphase.addr, cdac_pkg::ADDR_DATA_HIGH);
    wr_low     = aphase.valid && aphase.write && reg_index_hit(aphase.addr, cdac_pkg::ADDR_DATA_LOW);
  end

  // always ready, always OKAY
  // every register settles in one edge, so no wait state is ever needed
  assign hreadyout = 1'b1;
  // nothing is refused: unmapped words read zero instead of erroring
  assign hresp     = 1'b0;

  // read mux, combinational in data phase
  // zero outside a read data phase so the shared read bus stays quiet
  always_comb begin
    // default keeps unmapped words and idle cycles at zero
    hrdata = 32'h0000_0000;
    // only a read of this slave puts data on the bus
    if (aphase.valid && !aphase.write) begin
      case (aphase.addr)
        // byte registers sit in the low lane
        cdac_pkg::ADDR_CONTROL:   hrdata = {24'h000000, dac_control};
        cdac_pkg::ADDR_DATA_HIGH: hrdata = {24'h000000, dac_data_high};
        cdac_pkg::ADDR_DATA_LOW:  hrdata = {24'h000000, dac_data_low};
        // live latch contents, shows whether an update happened
        cdac_pkg::ADDR_LATCH:     hrdata = {22'h0, input_latch};
        default:                  hrdata = 32'h0000_0000;
      endcase
    end
  end

  // register writes; unused control bits 3:2 stay zero
  // the bytes only hold data; the latch copy happens elsewhere
  always_comb begin
    // hold unless written
    next_dac_control   = dac_control;
    next_dac_data_high = dac_data_high;
    next_dac_data_low  = dac_data_low;
    // mode and range changes apply from the next cycle
    if (wr_control) begin
      next_dac_control = hwdata[7:0] & cdac_pkg::CONTROL_WMASK;
    end
    // high byte is all data bits
    if (wr_high) begin
      next_dac_data_high = hwdata[7:0];
    end
    // low byte keeps only its two data bits, the rest read zero
    // RULE_13: low byte bits
    if (wr_low) begin
      next_dac_data_low = hwdata[7:0] & cdac_pkg::LOW_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    // data bytes reset to zero so an early event loads a known word
    if (!hresetn) begin
      // RULE_02: control reset value
      dac_control   <= cdac_pkg::CONTROL_RESET;
      dac_data_high <= cdac_pkg::DATA_RESET;
      dac_data_low  <= cdac_pkg::DATA_RESET;
    end else begin
      dac_control   <= next_dac_control;
      dac_data_high <= next_dac_data_high;
      dac_data_low  <= next_dac_data_low;
    end
  end

  // RULE_14: two-stage sync, edge from stage two
  // costs three cycles of latency between pin edge and output update
  always_comb begin
    // pin sampled as it stands, then passed down the chain
    next_strobe_meta = external_conversion_strobe;
    next_strobe_sync = strobe_meta;
    next_strobe_prev = strobe_sync;
  end

  // sync chain starts low; a high pin at reset gives one rise later
  // a strobe pulse shorter than one clock may be missed entirely
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // all low, the same as an idle pin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_prev <= 1'b0;
    end else begin
      strobe_meta <= next_strobe_meta;
      strobe_sync <= next_strobe_sync;
      strobe_prev <= next_strobe_prev;
    end
  end

  // edge pulses last one cycle each
  // both come from settled samples, never from the raw pin
  assign rise_pulse = strobe_sync && !strobe_prev;
  assign fall_pulse = !strobe_sync && strobe_prev;

  // update source field of the control register
  assign src = dac_control[cdac_pkg::SRC_MSB:cdac_pkg::SRC_LSB];

  // update event selection
  // only the selected source counts; the others are ignored, not queued
  always_comb begin
    // no load unless the chosen source fires
    load_latch = 1'b0;
    case (src)
      // RULE_10: timer overflow select
      // RULE_15: overflow pulse loads directly
      cdac_pkg::SRC_TMR0:       load_latch = timer_overflow[0];
      cdac_pkg::SRC_TMR1:       load_latch = timer_overflow[1];
      cdac_pkg::SRC_TMR2:       load_latch = timer_overflow[2];
      cdac_pkg::SRC_TMR3:       load_latch = timer_overflow[3];
      // RULE_11: strobe edge select
      // RULE_12: rise, fall, both
      cdac_pkg::SRC_RISE:       load_latch = rise_pulse;
      cdac_pkg::SRC_FALL:       load_latch = fall_pulse;
      cdac_pkg::SRC_BOTH:       load_latch = rise_pulse || fall_pulse;
      // RULE_06: high-byte write triggers
      cdac_pkg::SRC_HIGH_WRITE: load_latch = wr_high;
      // every code is decoded above; this keeps the case complete
      default:                  load_latch = 1'b0;
    endcase
  end

  // bytes as they stand after this cycle's write, so a write
  // coinciding with an event is not lost
  // trade-off: a longer path from the bus data to the latch
  always_comb begin
    high_now = next_dac_data_high;
    low_now  = next_dac_data_low;
  end

  // RULE_07: latch moves only on the event
  // data writes alone reach the converter only with source 111, where the high-byte write is the event
  always_comb begin
    // hold the converter word between events
    next_input_latch = input_latch;
    if (load_latch) begin
      // RULE_13: left-justified packing
      next_input_latch = pack_word(high_now, low_now);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    // zero word so the output starts at no current
    if (!hresetn) begin
      input_latch <= 10'h000;
    end else begin
      input_latch <= next_input_latch;
    end
  end

  // analog side outputs from registers
  // all fields follow flip-flops, so the current source sees no glitches
  always_comb begin
    // converter on while the enable bit is set
    analog.enable   = dac_control[cdac_pkg::EN_BIT];
    // RULE_04: bias request follows enable
    analog.bias_req = dac_control[cdac_pkg::EN_BIT];
    // RULE_01: 1x collapses to 2 mA
    // upper bit set wins, whatever the lower bit says
    if (dac_control[cdac_pkg::FS_MSB]) begin
      analog.range = cdac_pkg::RANGE_2MA;
    end else if (dac_control[cdac_pkg::FS_LSB]) begin
      analog.range = cdac_pkg::RANGE_1MA;
    end else begin
      // code 00, smallest range
      analog.range = cdac_pkg::RANGE_0P5MA;
    end
    // converter word straight from the input latch
    analog.code     = input_latch;
  end

  // RULE_03: pin takeover when enabled
  // drivers and pullup off while enabled, else the pad loads the output current
  always_comb begin
    // analog switch closes with the enable bit
    pin_analog_connect = dac_control[cdac_pkg::EN_BIT];
    // disabled: ordinary port pin, controls pass straight through
    pin_out            = dac_control[cdac_pkg::EN_BIT] ? 1'b0 : gpio_out;
    pin_oe             = dac_control[cdac_pkg::EN_BIT] ? 1'b0 : gpio_oe;
    pin_pullup_en      = dac_control[cdac_pkg::EN_BIT] ? 1'b0 : gpio_pullup_en;
  end

endmodule

// File: hdl/cdac_pkg.sv
package cdac_pkg;
  // register byte addresses (one word each)
  localparam logic [11:0] ADDR_CONTROL   = 12'h000;
  localparam logic [11:0] ADDR_DATA_HIGH = 12'h004;
  localparam logic [11:0] ADDR_DATA_LOW  = 12'h008;
  localparam logic [11:0] ADDR_LATCH     = 12'h00C;
  localparam logic [11:0] ADDR_MASK      = 12'hFFC;
  // control register layout
  localparam int          EN_BIT         = 7;
  localparam int          SRC_MSB        = 6;
  localparam int          SRC_LSB        = 4;
  localparam int          FS_MSB         = 1;
  localparam int          FS_LSB         = 0;
  localparam logic [7:0]  CONTROL_RESET  = 8'h72;
  localparam logic [7:0]  CONTROL_WMASK  = 8'hF3;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [7:0]  LOW_WMASK      = 8'hC0;
  // update source codes
  localparam logic [2:0]  SRC_TMR0       = 3'h0;
  localparam logic [2:0]  SRC_TMR1       = 3'h1;
  localparam logic [2:0]  SRC_TMR2       = 3'h2;
  localparam logic [2:0]  SRC_TMR3       = 3'h3;
  localparam logic [2:0]  SRC_RISE       = 3'h4;
  localparam logic [2:0]  SRC_FALL       = 3'h5;
  localparam logic [2:0]  SRC_BOTH       = 3'h6;
  localparam logic [2:0]  SRC_HIGH_WRITE = 3'h7;
  // full-scale range codes on the analog side
  localparam logic [1:0]  RANGE_0P5MA    = 2'h0;
  localparam logic [1:0]  RANGE_1MA      = 2'h1;
  localparam logic [1:0]  RANGE_2MA      = 2'h2;
  // AHB constants
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

  // analog-facing control bundle
  typedef struct packed {
    logic       enable;      // converter on, pin handed over
    logic       bias_req;    // bandgap bias request
    logic [1:0] range;       // full-scale current code
    logic [9:0] code;        // input latch word
  } cdac_analog_t;

  // captured address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } cdac_aphase_t;
endpackage

// File: test/cdac_top_sva.sv
`timescale 1ns/1ns
// port-level checks of the converter control block
module cdac_top_sva (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic                   hwrite,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [3:0]             timer_overflow,
  input wire logic                   external_conversion_strobe,
  input wire logic                   gpio_out,
  input wire logic                   gpio_oe,
  input wire logic                   gpio_pullup_en,
  input wire logic                   pin_out,
  input wire logic                   pin_oe,
  input wire logic                   pin_pullup_en,
  input wire logic                   pin_analog_connect,
  input wire cdac_pkg::cdac_analog_t analog
);
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // zero-wait slave: a stall here would hang any master
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not zero-wait okay");
  property p_gpio; !analog.enable |-> {pin_out, pin_oe, pin_pullup_en} == {gpio_out, gpio_oe, gpio_pullup_en}; endproperty
  a_gpio: assert property (p_gpio) else $error("pin not ordinary while disabled");
  property p_off; analog.enable |-> !pin_out && !pin_oe && !pin_pullup_en; endproperty
  a_off: assert property (p_off) else $error("pin drivers on while enabled");
  property p_conn; pin_analog_connect == analog.enable; endproperty
  a_conn: assert property (p_conn) else $error("analog connect differs from enable");
  property p_bias; analog.bias_req == analog.enable; endproperty
  a_bias: assert property (p_bias) else $error("bias request differs from enable");
  property p_range; analog.range != 2'h3; endproperty
  a_range: assert property (p_range) else $error("range code outside three settings");
  property p_rst; $rose(hresetn) |-> analog.range == 2'h2 && !analog.enable && analog.code == 10'h000; endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  // word moves only two edges after a write address phase, one edge after
  // a timer pulse, or three edges after a change of the strobe pin
  property p_hold;
    $changed(analog.code) |-> ($past(hsel, 2) && $past(hwrite, 2)) || (|$past(timer_overflow)) ||
      ($past(external_conversion_strobe, 3) != $past(external_conversion_strobe, 4));
  endproperty
  a_hold: assert property (p_hold) else $error("converter word changed with no update event");
endmodule
bind cdac_top cdac_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite),
  .hreadyout(hreadyout), .hresp(hresp), .timer_overflow(timer_overflow),
  .external_conversion_strobe(external_conversion_strobe),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pullup_en(gpio_pullup_en), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en), .pin_analog_connect(pin_analog_connect), .analog(analog));

// File: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                   hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, strobe = 0;
  logic [2:0]             gpio = 3'h7;  // pin skipped by crossbar, port latch only
  logic [31:0]            haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]             htrans = '0;
  logic [3:0]             timer_overflow = '0;
  logic                   hreadyout, hresp, pin_out, pin_oe, pin_pullup_en, pin_analog_connect;
  cdac_pkg::cdac_analog_t analog;
  logic [9:0]             exp_code = '0;  // model of the input latch
  int                     fail_count = 0, n_tests = 0;
  always #25 hclk = ~hclk;
  // gpio side driven by the bench so the pass-through is visible
  cdac_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_overflow(timer_overflow), .external_conversion_strobe(strobe), .gpio_out(gpio[2]), .gpio_oe(gpio[1]),
    .gpio_pullup_en(gpio[0]), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_analog_connect(pin_analog_connect), .analog(analog));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_code;
    chk({22'h0, analog.code}, {22'h0, exp_code});
  endtask
  // single transfer; read data taken at the rising edge that ends the data phase
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= cdac_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(negedge hclk);
  endtask
  // full word: low byte first, then high
  task automatic wr_data(input logic [7:0] h, input logic [7:0] l);
    ahb(1'b1, cdac_pkg::ADDR_DATA_LOW, l);
    ahb(1'b1, cdac_pkg::ADDR_DATA_HIGH, h);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge hclk);
    timer_overflow <= m;
    @(posedge hclk);
    timer_overflow <= 4'h0;
    @(negedge hclk);
  endtask
  // five edges cover the two-flop sync plus edge detect and load
  task automatic strobe_to(input logic v);
    @(posedge hclk);
    strobe <= v;
    repeat (5) @(posedge hclk);
    @(negedge hclk);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, cdac_pkg::ADDR_CONTROL, 8'h00);
    chk(rd, 32'h72);
    chk({18'h0, analog}, 32'h800);
    ahb(1'b1, cdac_pkg::ADDR_CONTROL, 8'hFF);
    ahb(1'b0, cdac_pkg::ADDR_CONTROL, 8'h00);
    chk(rd, 32'hF3);
    chk({26'h0, pin_out, pin_oe, pin_pullup_en, pin_analog_connect, analog.enable, analog.bias_req}, 32'h7);
    for (int r = 0; r < 4; r++) begin
      ahb(1'b1, cdac_pkg::ADDR_CONTROL, 8'h70 | 8'(r));
      chk({30'h0, analog.range}, r[1] ? 32'h2 : 32'(r));
    end
    @(posedge hclk);
    gpio <= 3'h2;
    @(negedge hclk);
    chk({28'h0, pin_out, pin_oe, pin_pullup_en, pin_analog_connect}, 32'h4);
    ahb(1'b1, cdac_pkg::ADDR_DATA_LOW, 8'hFF);
    ahb(1'b0, cdac_pkg::ADDR_DATA_LOW, 8'h00);
    chk(rd, 32'hC0);
    ahb(1'b1, cdac_pkg::ADDR_DATA_LOW, 8'hC0);
    chk_code();
    ahb(1'b1, cdac_pkg::ADDR_DATA_HIGH, 8'hA5);
    exp_code = 10'h297;
    chk_code();
    ahb(1'b0, cdac_pkg::ADDR_LATCH, 8'h00);
    chk(rd, 32'h297);
    ahb(1'b0, cdac_pkg::ADDR_DATA_HIGH, 8'h00);
    chk(rd, 32'hA5);
    ahb(1'b1, cdac_pkg::ADDR_DATA_LOW, 8'h00);
    ahb(1'b1, cdac_pkg::ADDR_DATA_HIGH, 8'h3C);
    exp_code = 10'h0F0;
    chk_code();
    for (int n = 0; n < 4; n++) begin
      ahb(1'b1, cdac_pkg::ADDR_CONTROL, {1'b0, n[2:0], 4'h2});
      wr_data(8'h30 + 8'(n), 8'h40);
      chk_code();
      pulse(4'h1 << ((n + 1) % 4));
      chk_code();
      pulse(4'h1 << n);
      exp_code = {8'h30 + 8'(n), 2'h1};
      chk_code();
    end
    for (int k = 0; k < 3; k++) begin
      ahb(1'b1, cdac_pkg::ADDR_CONTROL, {1'b0, 3'(4 + k), 4'h2});
      wr_data(8'h50 + 8'(k), 8'h80);
      chk_code();
      strobe_to(1'b1);
      if (k != 1) exp_code = {8'h50 + 8'(k), 2'h2};
      chk_code();
      wr_data(8'h60 + 8'(k), 8'hC0);
      strobe_to(1'b0);
      if (k != 0) exp_code = {8'h60 + 8'(k), 2'h3};
      chk_code();
    end
    ahb(1'b0, 12'h010, 8'h00);
    chk(rd, 32'h0);
    // second reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, cdac_pkg::ADDR_CONTROL, 8'h00);
    exp_code = 10'h000;
    chk(rd, 32'h72);
    chk_code();
    complete_run();
  end
  // hang guard, well past the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    complete_run();
  end
endmodule
